// File: design/vpt_pkg.sv
`default_nettype none
package vpt_pkg;
	localparam int VID_W = 12;
	localparam logic [11:0] VID_MIN = 12'h001;
	localparam logic [11:0] VID_MAX = 12'hFFE;
	localparam logic [11:0] VID_DEFAULT = 12'h001;
	localparam logic [11:0] MGMT_VID = 12'h001;
	localparam int NAME_WORDS = 8;
	localparam logic [11:0] OFS_GROUP_EN = 12'h000;
	localparam logic [11:0] OFS_WIRELESS = 12'h004;
	localparam logic [11:0] OFS_STATUS = 12'h008;
	localparam logic [11:0] OFS_DROP_CNT = 12'h00C;
	localparam logic [11:0] OFS_PORT_BASE = 12'h100;
	localparam logic [11:0] OFS_VLAN_BASE = 12'h400;
	localparam int ENT_ID = 0;
	localparam int ENT_PORTS = 1;
	localparam int ENT_NAME0 = 2;
	localparam int ID_VALID_BIT = 31;
	localparam int PORT_DROP_UNTAG_BIT = 12;
	localparam int PORT_DROP_NONMEM_BIT = 13;
	localparam int PORT_TAG_SHIFT = 16;
	localparam int STATUS_ERR_BIT = 0;
	localparam logic [31:0] MGMT_NAME_W0 = 32'h616E614D;
	localparam logic [31:0] MGMT_NAME_W1 = 32'h656D6567;
	localparam logic [31:0] MGMT_NAME_W2 = 32'h0000746E;
endpackage : vpt_pkg
`default_nettype wire

// File: design/vpt_vlan_port_tag_filter.sv
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module vpt_vlan_port_tag_filter #(
	parameter int NUM_PORTS = 4,
	parameter int NUM_GROUPS = 2,
	parameter int NUM_VLANS = 8,
	parameter int PORT_IDX_W = 2,
	parameter int GROUP_IDX_W = 1
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [11:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output var logic [31:0] regRdData,
	input wire logic frmValid,
	input wire logic [PORT_IDX_W-1:0] frmPort,
	input wire logic [GROUP_IDX_W-1:0] frmGroup,
	input wire logic frmTagged,
	input wire logic [vpt_pkg::VID_W-1:0] frmVid,
	output var logic decValid,
	output var logic decDrop,
	output var logic decBypass,
	output var logic [vpt_pkg::VID_W-1:0] decVid,
	output var logic [NUM_PORTS-1:0] decMembers,
	output var logic [NUM_PORTS-1:0] decTagOut
);
	import vpt_pkg::*;

	typedef struct packed {
		logic [NUM_GROUPS-1:0] groupEn;
		logic [NUM_PORTS-1:0] wireless;
		logic [NUM_PORTS-1:0][VID_W-1:0] portVid;
		logic [NUM_PORTS-1:0] dropUntag;
		logic [NUM_PORTS-1:0] dropNonMem;
		logic [NUM_VLANS-1:0] entValid;
		logic [NUM_VLANS-1:0][VID_W-1:0] entVid;
		logic [NUM_VLANS-1:0][NUM_PORTS-1:0] entMember;
		logic [NUM_VLANS-1:0][NUM_PORTS-1:0] entTag;
		logic [NUM_VLANS-1:0][NAME_WORDS-1:0][31:0] entName;
		logic writeErr;
		logic [15:0] dropCnt;
		logic [31:0] rdData;
		logic outValid;
		logic outDrop;
		logic outBypass;
		logic [VID_W-1:0] outVid;
		logic [NUM_PORTS-1:0] outMembers;
		logic [NUM_PORTS-1:0] outTag;
	} vpt_state_s;

	vpt_state_s st_r;
	vpt_state_s st_nxt;

	// register map, byte addresses on the plain register port
	// 0x000 group enable, one bit per bridge group
	// 0x004 wireless port mask, one bit per port
	// 0x008 status: bit 0 is the sticky write error, write 1 to clear
	// 0x00C dropped frame counter, 16 bits, read only, wraps
	// 0x100 + 4*p port p:
	//   [11:0] default vid, [12] drop untagged, [13] drop non-members
	// 0x400 + 0x40*e vlan entry e:
	//   +0x00 [11:0] vid, [31] valid
	//   +0x04 [NUM_PORTS-1:0] members, [16 +: NUM_PORTS] egress tagged
	//   +0x08 .. +0x24 name words 0 to 7, first char in bits 7:0
	// unmapped addresses: writes ignored, reads return zero
	//
	// entry id word:
	//   valid=1 on a free entry creates it, if the vid is legal and both vid and name are unique
	//   valid=0 on a live entry deletes it and parks its vid at the default
	//   valid=1 with a different vid on a live entry is refused
	// refused writes leave state alone and raise the write error bit, except that a port write still takes its drop bits
	//
	// limitation: uniqueness is only checked among live entries,
	// so a free entry may hold any name until it is created
	//
	// frame decision is one cycle after the header; no stall, no buffer
	// dec outputs change every cycle, trust them only with decValid

	function automatic logic vpt_ent_hit(input logic [11:0] a);
		vpt_ent_hit = ((a & 12'hC03) == OFS_VLAN_BASE) && (int'(a[9:6]) < NUM_VLANS);
	endfunction : vpt_ent_hit

	function automatic logic vpt_port_hit(input logic [11:0] a);
		vpt_port_hit = ((a & 12'hFC3) == OFS_PORT_BASE) && (int'(a[5:2]) < NUM_PORTS);
	endfunction : vpt_port_hit

	function automatic logic vpt_vid_ok(input logic [VID_W-1:0] v);
		vpt_vid_ok = (v >= VID_MIN) && (v <= VID_MAX);
	endfunction : vpt_vid_ok

	always_comb begin
		logic [NAME_WORDS-1:0][31:0] cand;
		logic dupName;
		logic dupVid;
		logic hit;
		logic untag;
		logic isWl;
		logic [VID_W-1:0] effVid;
		logic [NUM_PORTS-1:0] mem;
		logic [NUM_PORTS-1:0] tagm;
		logic [NUM_PORTS-1:0] srcBit;
		int e;
		int w;
		int p;
		cand = '0;
		dupName = 1'b0;
		dupVid = 1'b0;
		hit = 1'b0;
		untag = 1'b0;
		isWl = 1'b0;
		effVid = '0;
		mem = '0;
		tagm = '0;
		srcBit = '0;
		e = int'(regAddr[9:6]);
		w = int'(regAddr[5:2]);
		p = int'(regAddr[5:2]);
		st_nxt = st_r;
		st_nxt.rdData = '0;
		// read data stands for one cycle only, then falls back to zero


		// names and ids of other live entries, for uniqueness checks
		if (vpt_ent_hit(regAddr)) begin
			cand = st_r.entName[e];
			if (w >= ENT_NAME0 && w < ENT_NAME0 + NAME_WORDS) begin
				cand[w - ENT_NAME0] = regWrData;
			end
			for (int v = 0; v < NUM_VLANS; v++) begin
				if (v != e && st_r.entValid[v]) begin
					if (st_r.entName[v] == cand) begin
						dupName = 1'b1;
					end
					if (st_r.entVid[v] == regWrData[VID_W-1:0]) begin
						dupVid = 1'b1;
					end
				end
			end
		end


		// register writes; a refused write raises the error bit, and a refused port write still sets its drop bits
		if (regWrite) begin
			if (regAddr == OFS_GROUP_EN) begin
				st_nxt.groupEn = regWrData[NUM_GROUPS-1:0];
			end else if (regAddr == OFS_WIRELESS) begin
				st_nxt.wireless = regWrData[NUM_PORTS-1:0];
			end else if (regAddr == OFS_STATUS) begin
				if (regWrData[STATUS_ERR_BIT]) begin
					st_nxt.writeErr = 1'b0;
				end
			end else if (vpt_port_hit(regAddr)) begin
				st_nxt.dropUntag[p] = regWrData[PORT_DROP_UNTAG_BIT];
				st_nxt.dropNonMem[p] = regWrData[PORT_DROP_NONMEM_BIT];
				if (vpt_vid_ok(regWrData[VID_W-1:0])) begin
					st_nxt.portVid[p] = regWrData[VID_W-1:0];
				end else begin
					st_nxt.writeErr = 1'b1;
				end
			end else if (vpt_ent_hit(regAddr)) begin
				if (w == ENT_ID) begin
					if (st_r.entValid[e]) begin
						// a live id cannot be rewritten, only the entry removed
						if (!regWrData[ID_VALID_BIT]) begin
							st_nxt.entValid[e] = 1'b0;
							st_nxt.entVid[e] = VID_DEFAULT;
						end else if (regWrData[VID_W-1:0] != st_r.entVid[e]) begin
							st_nxt.writeErr = 1'b1;
						end
					end else if (regWrData[ID_VALID_BIT]) begin
						if (vpt_vid_ok(regWrData[VID_W-1:0]) && !dupVid && !dupName) begin
							st_nxt.entValid[e] = 1'b1;
							st_nxt.entVid[e] = regWrData[VID_W-1:0];
						end else begin
							st_nxt.writeErr = 1'b1;
						end
					end
				end else if (w == ENT_PORTS) begin
					st_nxt.entMember[e] = regWrData[NUM_PORTS-1:0];
					st_nxt.entTag[e] = regWrData[PORT_TAG_SHIFT+NUM_PORTS-1:PORT_TAG_SHIFT];
				end else if (w >= ENT_NAME0 && w < ENT_NAME0 + NAME_WORDS) begin
					if (st_r.entValid[e] && dupName) begin
						st_nxt.writeErr = 1'b1;
					end else begin
						st_nxt.entName[e] = cand;
					end
				end
			end
		end


		// register reads, answered from the registered state
		if (regRead) begin
			if (regAddr == OFS_GROUP_EN) begin
				st_nxt.rdData = 32'(st_r.groupEn);
			end else if (regAddr == OFS_WIRELESS) begin
				st_nxt.rdData = 32'(st_r.wireless);
			end else if (regAddr == OFS_STATUS) begin
				st_nxt.rdData = 32'(st_r.writeErr);
			end else if (regAddr == OFS_DROP_CNT) begin
				st_nxt.rdData = 32'(st_r.dropCnt);
			end else if (vpt_port_hit(regAddr)) begin
				st_nxt.rdData = 32'(st_r.portVid[p]);
				st_nxt.rdData[PORT_DROP_UNTAG_BIT] = st_r.dropUntag[p];
				st_nxt.rdData[PORT_DROP_NONMEM_BIT] = st_r.dropNonMem[p];
			end else if (vpt_ent_hit(regAddr)) begin
				if (w == ENT_ID) begin
					st_nxt.rdData = 32'(st_r.entVid[e]);
					st_nxt.rdData[ID_VALID_BIT] = st_r.entValid[e];
				end else if (w == ENT_PORTS) begin
					st_nxt.rdData = 32'(st_r.entMember[e]) | (32'(st_r.entTag[e]) << PORT_TAG_SHIFT);
				end else if (w >= ENT_NAME0 && w < ENT_NAME0 + NAME_WORDS) begin
					st_nxt.rdData = st_r.entName[e][w - ENT_NAME0];
				end
			end
		end


		// one frame header per cycle, decision one cycle later
		// in an enabled group wireless ports take their default id, tagged or not
		isWl = st_r.wireless[frmPort];
		untag = !frmTagged || isWl;
		srcBit = NUM_PORTS'(1) << frmPort;
		effVid = untag ? st_r.portVid[frmPort] : frmVid;
		for (int v = 0; v < NUM_VLANS; v++) begin
			if (st_r.entValid[v] && st_r.entVid[v] == effVid) begin
				hit = 1'b1;
				mem = st_r.entMember[v];
				tagm = st_r.entTag[v];
			end
		end
		st_nxt.outValid = frmValid;
		st_nxt.outVid = effVid;
		st_nxt.outBypass = 1'b0;
		st_nxt.outDrop = 1'b0;
		st_nxt.outMembers = hit ? (mem & ~srcBit) : '0;
		// wireless clients see no tag unless the group is bypassed
		st_nxt.outTag = tagm & ~st_r.wireless;
		if (!st_r.groupEn[frmGroup]) begin
			st_nxt.outBypass = 1'b1;
			st_nxt.outVid = frmVid;
			st_nxt.outMembers = ~srcBit;
			st_nxt.outTag = frmTagged ? '1 : '0;
		end else if (untag && !isWl && st_r.dropUntag[frmPort]) begin
			st_nxt.outDrop = 1'b1;
		end else if (!untag && st_r.dropNonMem[frmPort] && !(hit && mem[frmPort])) begin
			st_nxt.outDrop = 1'b1;
		end

		// counter wraps silently; software reads it as a rate, not a total
		if (frmValid && st_nxt.outDrop) begin
			st_nxt.dropCnt = st_r.dropCnt + 16'h0001;
		end
	end


	// synchronous reset loads the management entry and disables all groups
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st_r <= '0;
			st_r.entValid[0] <= 1'b1;
			st_r.entVid <= {NUM_VLANS{VID_DEFAULT}};
			st_r.entVid[0] <= MGMT_VID;
			st_r.entMember[0] <= '1;
			st_r.portVid <= {NUM_PORTS{MGMT_VID}};
			st_r.entName[0][0] <= MGMT_NAME_W0;
			st_r.entName[0][1] <= MGMT_NAME_W1;
			st_r.entName[0][2] <= MGMT_NAME_W2;
		end else begin
			st_r <= st_nxt;
		end
	end


	// every output is a field of the state register
	assign regRdData = st_r.rdData;
	assign decValid = st_r.outValid;
	assign decDrop = st_r.outDrop;
	assign decBypass = st_r.outBypass;
	assign decVid = st_r.outVid;
	assign decMembers = st_r.outMembers;
	assign decTagOut = st_r.outTag;
endmodule : vpt_vlan_port_tag_filter
`default_nettype wire

// File: tb/vpt_filter_properties.sv
`timescale 1ns/100ps
`default_nettype none
module vpt_filter_properties #(
	parameter int NUM_PORTS = 4,
	parameter int PORT_IDX_W = 2
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic regRead,
	input wire logic [31:0] regRdData,
	input wire logic frmValid,
	input wire logic [PORT_IDX_W-1:0] frmPort,
	input wire logic frmTagged,
	input wire logic [11:0] frmVid,
	input wire logic decValid,
	input wire logic decDrop,
	input wire logic decBypass,
	input wire logic [11:0] decVid,
	input wire logic [NUM_PORTS-1:0] decMembers,
	input wire logic [NUM_PORTS-1:0] decTagOut
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	a_dec_follows_frame: assert property (frmValid |=> decValid) else $error("decision missing");
	a_dec_no_spurious: assert property (!frmValid |=> !decValid) else $error("decision without frame");
	a_read_data_idle: assert property (!regRead |=> regRdData == 32'h0) else $error("read data not idle");
	a_source_excluded: assert property (frmValid |=> decMembers[$past(frmPort)] == 1'b0) else $error("source in members");
	a_bypass_vid_kept: assert property (decValid && decBypass |-> decVid == $past(frmVid) && !decDrop) else $error("bypass changed frame");
	a_bypass_tag_kept: assert property (decValid && decBypass |-> decTagOut == {NUM_PORTS{$past(frmTagged)}}) else $error("bypass tag");
	a_vid_in_range: assert property (decValid && !decBypass && !decDrop && decMembers != '0 |-> decVid inside {[12'h001:12'hFFE]}) else $error("vid range");
	a_reset_quiet: assert property (!reset && $past(reset) |-> !decValid && regRdData == 32'h0) else $error("outputs after reset");
endmodule : vpt_filter_properties
bind vpt_vlan_port_tag_filter vpt_filter_properties #(.NUM_PORTS(NUM_PORTS), .PORT_IDX_W(PORT_IDX_W)) u_props (.sys_clk,
	.reset, .regRead, .regRdData, .frmValid, .frmPort, .frmTagged, .frmVid, .decValid, .decDrop, .decBypass, .decVid,
	.decMembers, .decTagOut);
`default_nettype wire

// File: tb/vpt_mac_model.sv
`timescale 1ns/100ps
`default_nettype none
// ingress mac: one header per request; idle vid toggles so stale ids never look valid
module vpt_mac_model (
	input wire logic sys_clk,
	input wire logic sendReq,
	input wire logic [1:0] reqPort,
	input wire logic reqGroup,
	input wire logic reqTagged,
	input wire logic [11:0] reqVid,
	output var logic frmValid,
	output var logic [1:0] frmPort,
	output var logic [0:0] frmGroup,
	output var logic frmTagged,
	output var logic [11:0] frmVid
);
	initial begin
		frmValid = 1'b0;
		{frmPort, frmGroup, frmTagged, frmVid} = '0;
	end
	always @(posedge sys_clk) begin
		frmValid <= sendReq;
		if (sendReq) begin
			{frmPort, frmGroup, frmTagged, frmVid} <= {reqPort, reqGroup, reqTagged, reqVid};
		end else begin
			frmVid <= ~frmVid;
		end
	end
endmodule : vpt_mac_model
`default_nettype wire

// File: tb/vlan_port_tag_filter_tb.sv
`timescale 1ns/100ps
`default_nettype none
module vlan_port_tag_filter_tb;
	import vpt_pkg::*;
	logic sys_clk = 0, reset = 1, regWrite = 0, regRead = 0, sendReq = 0, reqGroup = 0, reqTagged = 0;
	logic [11:0] regAddr = '0, reqVid = '0, frmVid, decVid;
	logic [31:0] regWrData = '0, regRdData;
	logic [1:0] reqPort = '0, frmPort;
	logic [0:0] frmGroup;
	logic frmValid, frmTagged, decValid, decDrop, decBypass;
	logic [3:0] decMembers, decTagOut;
	int errCount = 0, comparisons = 0;
	vpt_mac_model u_vpt_mac_model (.sys_clk, .sendReq, .reqPort, .reqGroup, .reqTagged, .reqVid, .frmValid, .frmPort,
		.frmGroup, .frmTagged, .frmVid);
	vpt_vlan_port_tag_filter u_vpt_vlan_port_tag_filter (.sys_clk, .reset, .regAddr, .regWrData, .regWrite, .regRead,
		.regRdData, .frmValid, .frmPort, .frmGroup, .frmTagged, .frmVid, .decValid, .decDrop, .decBypass, .decVid,
		.decMembers, .decTagOut);
	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			errCount++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk) {regWrite, regAddr, regWrData} <= {1'b1, a, d};
		@(posedge sys_clk) regWrite <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		@(posedge sys_clk) {regRead, regAddr} <= {1'b1, a};
		@(posedge sys_clk) regRead <= 1'b0;
		#1 chk("regRdData", exp, regRdData);
	endtask : rd
	// frame goes model -> design -> decision, so the decision shows after the third edge
	task automatic frm(input logic [1:0] p, input logic g, t, input logic [11:0] v, input logic dr, by,
		input logic [11:0] ev, input logic [3:0] em, et);
		@(posedge sys_clk) {sendReq, reqPort, reqGroup, reqTagged, reqVid} <= {1'b1, p, g, t, v};
		@(posedge sys_clk) sendReq <= 1'b0;
		@(posedge sys_clk) #1;
		chk("decValid", 1, decValid);
		chk("decDrop", dr, decDrop);
		chk("decBypass", by, decBypass);
		chk("decVid", ev, decVid);
		chk("decMembers", em, decMembers);
		chk("decTagOut", et, decTagOut);
	endtask : frm
	task automatic results;
		if (errCount == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : results
	initial begin
		repeat (3) @(posedge sys_clk);
		reset <= 1'b0;
		rd(OFS_GROUP_EN, 0);
		rd(OFS_VLAN_BASE, 32'h80000001);
		rd(12'h404, 32'h0000000F);
		rd(12'h408, MGMT_NAME_W0);
		rd(12'h0F0, 0);
		frm(0, 0, 1, 12'h123, 0, 1, 12'h123, 4'hE, 4'hF);
		wr(OFS_GROUP_EN, 1);
		frm(1, 1, 0, 12'h007, 0, 1, 12'h007, 4'hD, 4'h0);
		frm(0, 0, 0, 12'h007, 0, 0, 12'h001, 4'hE, 4'h0);
		wr(OFS_PORT_BASE, 32'h00001000);
		rd(OFS_STATUS, 1);
		rd(OFS_PORT_BASE, 32'h00001001);
		wr(OFS_STATUS, 1);
		frm(0, 0, 0, 12'h007, 1, 0, 12'h001, 4'hE, 4'h0);
		wr(12'h440, 32'h80000005);
		wr(12'h444, 32'h000C0006);
		wr(OFS_PORT_BASE, 32'h00002001);
		frm(0, 0, 1, 12'h005, 1, 0, 12'h005, 4'h6, 4'hC);
		frm(1, 0, 1, 12'h005, 0, 0, 12'h005, 4'h4, 4'hC);
		rd(OFS_DROP_CNT, 32'h00000002);
		wr(12'h440, 32'h80000006);
		rd(12'h440, 32'h80000005);
		rd(OFS_STATUS, 1);
		wr(OFS_WIRELESS, 32'h8);
		wr(12'h10C, 32'h5);
		frm(3, 0, 1, 12'h009, 0, 0, 12'h005, 4'h6, 4'h4);
		results();
	end
endmodule : vlan_port_tag_filter_tb
`default_nettype wire
